// [src/ecmer_defs.svh]
// Offsets, field positions and reset values of the memory error reporting block
`ifndef ECMER_DEFS_SVH
`define ECMER_DEFS_SVH

// ----------------------------------------
// Processor board error page
// ----------------------------------------
`define ECMER_OFS_ERR 8'h00
`define ECMER_OFS_ADDR 8'h04
`define ECMER_BIT_CE 0
`define ECMER_BIT_UE 1
`define ECMER_BIT_WB 2
`define ECMER_BIT_TO 3
`define ECMER_BIT_EN_CE 4
`define ECMER_BIT_EN_INT 6
`define ECMER_BIT_INT 7
`define ECMER_ADDR_CX_LSB 28
`define ECMER_ADDR_DIRECT_VIRTUAL_ACCESS_BIT 31
`define ECMER_HI_LANE 3
`define ECMER_RST_FLAGS 3'h0

// ----------------------------------------
// Memory board page
// ----------------------------------------
`define ECMER_OFS_BENA 4'h0
`define ECMER_OFS_CE 4'h4
`define ECMER_BENA_BOARD_EN 5
`define ECMER_BENA_ECC_EN 6
`define ECMER_BENA_SCRUB_EN 7
`define ECMER_BENA_SIZE_LSB 8
`define ECMER_RST_BENA 8'h00
`define ECMER_CE_ADDR_LSB 1
`define ECMER_CE_SYN_LSB 24

`endif

// [src/ecmer_pkg.sv]
// Types shared by the memory error reporting block
`default_nettype none

package ecmer_pkg;
    typedef logic [27:0] ecmer_vaddr_t;
    typedef logic [2:0] ecmer_ctx_t;
    typedef logic [22:0] ecmer_raddr_t;
    typedef logic [7:0] ecmer_syn_t;
    typedef logic [3:0] ecmer_board_id_t;

    typedef struct packed {
        logic [7:0] ena;
        logic status;
        ecmer_raddr_t addr;
        ecmer_syn_t syn;
    } ecmer_board_state_t;

    typedef struct packed {
        logic frozen;
        logic direct_virtual_access;
        ecmer_ctx_t ctx;
        ecmer_vaddr_t va;
    } ecmer_addr_state_t;

    typedef struct packed {
        logic [3:1] flags;
        logic en_ce;
        logic en_int;
        logic int_pend;
        logic bus_err;
        logic rd_valid;
        logic [31:0] rdata;
    } ecmer_top_state_t;
endpackage : ecmer_pkg

`default_nettype wire

// [src/ecmer_board.sv]
// One memory board's enable register and first correctable error capture
`include "ecmer_defs.svh"
`default_nettype none

module ecmer_board #(
    parameter logic [1:0] SIZE_CODE = 2'b00
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Memory cycle aimed at this board
    input wire logic cyc_sel,
    input wire logic cyc_scrub,
    input wire logic cyc_ce,
    input wire logic cyc_ue,
    input wire ecmer_pkg::ecmer_syn_t cyc_syndrome,
    input wire ecmer_pkg::ecmer_raddr_t cyc_real_addr,
    // Register writes
    input wire logic ena_wr,
    input wire logic [7:0] ena_wdata,
    input wire logic ce_clear,
    // Register contents and reports
    output logic [15:0] ena_word,
    output logic [31:0] ce_word,
    output logic status,
    output logic ce_report,
    output logic ue_report
);
    import ecmer_pkg::*;

    ecmer_board_state_t st;
    ecmer_board_state_t next_st;
    logic checking;

    // ----------------------------------------
    // Error classification
    // ----------------------------------------
    assign checking = cyc_sel && st.ena[`ECMER_BENA_ECC_EN]; // see R01 see R02
    // UE wins over CE on the same word; scrub CE only with scrub on
    assign ce_report = checking && cyc_ce && !cyc_ue && (!cyc_scrub || st.ena[`ECMER_BENA_SCRUB_EN]); // see R17
    assign ue_report = checking && cyc_ue && !cyc_scrub; // see R03 see R10

    always_comb begin
        next_st = st;
        if (ena_wr) begin
            next_st.ena = ena_wdata;
        end
        // A new first error in the clearing cycle is kept
        if (ce_report && (!st.status || ce_clear)) begin
            next_st.status = 1'b1; // see R18
            next_st.addr = cyc_real_addr;
            next_st.syn = cyc_syndrome;
        end else if (ce_clear) begin
            next_st.status = 1'b0; // see R18
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{ena: `ECMER_RST_BENA, status: 1'b0, addr: '0, syn: '0};
        end else begin
            st <= next_st;
        end
    end

    assign ena_word = {6'h00, SIZE_CODE, st.ena};
    assign ce_word = {st.syn, st.addr, st.status};
    assign status = st.status;
endmodule : ecmer_board

`default_nettype wire

// [src/ecmer_addr.sv]
// Memory address register that freezes the first failing virtual address
`include "ecmer_defs.svh"
`default_nettype none

module ecmer_addr (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Capture and release
    input wire logic capture,
    input wire ecmer_pkg::ecmer_vaddr_t cap_vaddr,
    input wire ecmer_pkg::ecmer_ctx_t cap_ctx,
    input wire logic cap_direct_virtual_access,
    input wire logic unfreeze,
    // Register contents
    output logic [31:0] addr_word,
    output logic frozen
);
    import ecmer_pkg::*;

    ecmer_addr_state_t st;
    ecmer_addr_state_t next_st;

    always_comb begin
        next_st = st;
        // Fault in the releasing cycle is captured, not lost
        if (capture && (!st.frozen || unfreeze)) begin
            next_st = '{frozen: 1'b1, direct_virtual_access: cap_direct_virtual_access, ctx: cap_ctx, va: cap_vaddr}; // see R11
        end else if (unfreeze) begin
            next_st.frozen = 1'b0; // see R12
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign addr_word = {st.direct_virtual_access, st.ctx, st.va};
    assign frozen = st.frozen;
endmodule : ecmer_addr

`default_nettype wire

// [src/ecmer_top.sv]
// Memory error register, address freeze and board error collection
//
// Operation
// R01 - Both correctable and uncorrectable faults are detected on access and scrub cycles.
// R02 - ECC-enabled boards generate/check bits and report both classes on access cycles.
// R03 - On scrub cycles only correctable errors are reported; uncorrectable ones suppressed.
// R04 - Uncorrectable flag needs no enable; set on every reported access UE.
// R05 - Correctable flag is enable AND any board status; clears when all clear.
// R06 - With interrupt enable set, any of the four low flags raises pending.
// R07 - Pending drives the level 7 request and reads as the top bit.
// R08 - Direct access masters get a bus error only on read-data UE.
// R09 - Write and cache-related errors never reach the direct access master.
// R10 - Scrub-cycle uncorrectable errors never reach the processor.
// R11 - Address register freezes virtual address for flags three to one only.
// R12 - High-byte address write clears flags three to one, pending, and unfreezes.
// R13 - That clearing write leaves the correctable flag untouched.
// R14 - Error register layout: four RO flags, CE enable, unused, interrupt enable.
// R15 - Board registers selected by board number A7:A4 and select A3:A0.
// R16 - Software aligns each board base to a multiple of its size.
// R17 - Optional refresh scrub; its correctable errors are reported.
// R18 - Board status sets on first CE, freezes capture, cleared by write.
// R19 - Pending bit re-derived each cycle, held until flags clear.
`include "ecmer_defs.svh"
`default_nettype none

module ecmer_top #(
    parameter int NUM_BOARDS = 16,
    parameter logic [1:0] BOARD_SIZE_CODE = 2'b00
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,

    // Register access, processor page or board page
    input wire logic acc_board_page,
    input wire logic [7:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [3:0] acc_byte_en,
    input wire logic [31:0] acc_wdata,
    output logic [31:0] acc_rdata,
    output logic acc_rd_valid,

    // Memory cycle with its check result
    input wire logic cyc_valid,
    input wire logic cyc_scrub,
    input wire logic cyc_write,
    input wire logic cyc_direct_virtual_access,
    input wire logic cyc_cache,
    input wire ecmer_pkg::ecmer_board_id_t cyc_board,
    input wire logic cyc_ce,
    input wire logic cyc_ue,
    input wire ecmer_pkg::ecmer_syn_t cyc_syndrome,
    input wire ecmer_pkg::ecmer_raddr_t cyc_real_addr,
    input wire ecmer_pkg::ecmer_vaddr_t cyc_virt_addr,
    input wire ecmer_pkg::ecmer_ctx_t cyc_context,

    // Cache fault events
    input wire logic writeback_fail_evt,
    input wire logic bus_timeout_evt,
    input wire ecmer_pkg::ecmer_vaddr_t cache_fault_vaddr,
    input wire ecmer_pkg::ecmer_ctx_t cache_fault_context,

    // Results
    output logic irq_level7,
    output logic direct_virtual_access_bus_error,
    output logic [NUM_BOARDS-1:0] board_enable
);
    import ecmer_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ecmer_top_state_t st;
    ecmer_top_state_t next_st;

    logic [15:0] ena_word [NUM_BOARDS];
    logic [31:0] ce_word [NUM_BOARDS];
    logic [NUM_BOARDS-1:0] board_status;
    logic [NUM_BOARDS-1:0] board_ce;
    logic [NUM_BOARDS-1:0] board_ue;
    logic [NUM_BOARDS-1:0] ena_wr;
    logic [NUM_BOARDS-1:0] ce_clear;

    logic any_ue;
    logic ce_flag;
    logic err_wr;
    logic clear_wr;
    logic board_hit;
    logic [3:0] board_sel;
    logic [3:0] reg_sel;

    logic cap_any;
    ecmer_vaddr_t cap_vaddr;
    ecmer_ctx_t cap_ctx;
    logic cap_direct_virtual_access;
    logic [31:0] addr_word;
    logic [7:0] err_byte;
    logic [31:0] board_rdata;
    logic [31:0] cpu_rdata;

    logic berr_hit;

    // ----------------------------------------
    // Board page decode
    // ----------------------------------------
    assign board_sel = acc_addr[7:4]; // see R15
    assign reg_sel = acc_addr[3:0]; // see R15
    // Boards past NUM_BOARDS match nothing and read zero
    assign board_hit = acc_board_page && (int'(board_sel) < NUM_BOARDS);

    // ----------------------------------------
    // Memory boards
    // ----------------------------------------
    // Base compare lives in the memory decode; software keeps it size aligned (R16)
    for (genvar gi = 0; gi < NUM_BOARDS; gi++) begin : g_board
        logic sel_here;

        assign sel_here = board_hit && (board_sel == 4'(gi));
        assign ena_wr[gi] = acc_wr && sel_here && (reg_sel == `ECMER_OFS_BENA) && acc_byte_en[0];
        // Any write reaching the top byte of the CE register clears it
        assign ce_clear[gi] = acc_wr && sel_here && (reg_sel == `ECMER_OFS_CE) &&
                              acc_byte_en[`ECMER_HI_LANE]; // see R18
        assign board_enable[gi] = ena_word[gi][`ECMER_BENA_BOARD_EN];

        ecmer_board #(
            .SIZE_CODE(BOARD_SIZE_CODE)
        ) u_board (
            .clk_sys(clk_sys),
            .reset(reset),
            .cyc_sel(cyc_valid && (cyc_board == 4'(gi))),
            .cyc_scrub(cyc_scrub),
            .cyc_ce(cyc_ce),
            .cyc_ue(cyc_ue),
            .cyc_syndrome(cyc_syndrome),
            .cyc_real_addr(cyc_real_addr),
            .ena_wr(ena_wr[gi]),
            .ena_wdata(acc_wdata[7:0]),
            .ce_clear(ce_clear[gi]),
            .ena_word(ena_word[gi]),
            .ce_word(ce_word[gi]),
            .status(board_status[gi]),
            .ce_report(board_ce[gi]),
            .ue_report(board_ue[gi])
        );
    end

    // ----------------------------------------
    // Error collection
    // ----------------------------------------
    // Scrub UEs were dropped at the board, so none arrive here
    assign any_ue = |board_ue; // see R04 see R10

    // CE flag is pure status: no address capture and no clear by the clearing address write
    assign ce_flag = st.en_ce && (|board_status); // see R05 see R13

    // Capture priority UE, then a cache fault; write-back and time-out share one address
    assign cap_any = any_ue || writeback_fail_evt || bus_timeout_evt; // see R11

    // Cache faults never carry the direct access bit
    always_comb begin
        if (any_ue) begin
            cap_vaddr = cyc_virt_addr;
            cap_ctx = cyc_context;
            cap_direct_virtual_access = cyc_direct_virtual_access;
        end else begin
            cap_vaddr = cache_fault_vaddr;
            cap_ctx = cache_fault_context;
            cap_direct_virtual_access = 1'b0;
        end
    end

    // ----------------------------------------
    // Bus error to the direct access master
    // ----------------------------------------
    // Registered: the master sees it the cycle after its read
    assign berr_hit = cyc_valid && cyc_direct_virtual_access && !cyc_write && !cyc_cache && any_ue; // see R08 see R09

    // ----------------------------------------
    // Processor page decode
    // ----------------------------------------
    // Error byte in lane 0; the clearing write needs lane 3
    assign err_wr = acc_wr && !acc_board_page && (acc_addr == `ECMER_OFS_ERR) && acc_byte_en[0];
    assign clear_wr = acc_wr && !acc_board_page && (acc_addr == `ECMER_OFS_ADDR) &&
                      acc_byte_en[`ECMER_HI_LANE]; // see R12

    ecmer_addr u_addr (
        .clk_sys(clk_sys),
        .reset(reset),
        .capture(cap_any),
        .cap_vaddr(cap_vaddr),
        .cap_ctx(cap_ctx),
        .cap_direct_virtual_access(cap_direct_virtual_access),
        .unfreeze(clear_wr),
        .addr_word(addr_word),
        .frozen()
    );

    // ----------------------------------------
    // Read multiplexers
    // ----------------------------------------
    always_comb begin
        err_byte = 8'h00;
        err_byte[`ECMER_BIT_CE] = ce_flag; // see R14
        err_byte[`ECMER_BIT_UE] = st.flags[`ECMER_BIT_UE];
        err_byte[`ECMER_BIT_WB] = st.flags[`ECMER_BIT_WB];
        err_byte[`ECMER_BIT_TO] = st.flags[`ECMER_BIT_TO];
        err_byte[`ECMER_BIT_EN_CE] = st.en_ce;
        err_byte[`ECMER_BIT_EN_INT] = st.en_int;
        err_byte[`ECMER_BIT_INT] = st.int_pend; // see R07
    end

    always_comb begin
        unique case (acc_addr)
            `ECMER_OFS_ERR: begin
                cpu_rdata = {24'h00_0000, err_byte}; // see R14
            end
            `ECMER_OFS_ADDR: begin
                cpu_rdata = addr_word; // see R11
            end
            default: begin
                // Unmapped offsets read zero
                cpu_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        board_rdata = 32'h0000_0000;
        if (board_hit) begin
            unique case (reg_sel)
                `ECMER_OFS_BENA: begin
                    board_rdata = {16'h0000, ena_word[board_sel]};
                end
                `ECMER_OFS_CE: begin
                    board_rdata = ce_word[board_sel];
                end
                default: begin
                    board_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;

        // Enable bits; D5 stays zero
        if (err_wr) begin
            next_st.en_ce = acc_wdata[`ECMER_BIT_EN_CE]; // see R14
            next_st.en_int = acc_wdata[`ECMER_BIT_EN_INT]; // see R14
        end

        // Sticky flags: an event in the clearing cycle survives
        next_st.flags[`ECMER_BIT_UE] = any_ue ||
            (st.flags[`ECMER_BIT_UE] && !clear_wr); // see R04 see R12
        next_st.flags[`ECMER_BIT_WB] = writeback_fail_evt ||
            (st.flags[`ECMER_BIT_WB] && !clear_wr); // see R12
        next_st.flags[`ECMER_BIT_TO] = bus_timeout_evt ||
            (st.flags[`ECMER_BIT_TO] && !clear_wr); // see R12

        // Pending re-derived every cycle, so it drops with its cause
        next_st.int_pend = st.en_int && ((|next_st.flags) || ce_flag); // see R06 see R19

        // Only read-data UEs on direct access return a bus error
        next_st.bus_err = berr_hit; // see R08

        // Read data one cycle after the strobe
        next_st.rd_valid = acc_rd;
        if (acc_rd) begin
            if (acc_board_page) begin
                next_st.rdata = board_rdata;
            end else begin
                next_st.rdata = cpu_rdata;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{flags: `ECMER_RST_FLAGS, en_ce: 1'b0, en_int: 1'b0, int_pend: 1'b0,
                    bus_err: 1'b0, rd_valid: 1'b0, rdata: 32'h0000_0000};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign irq_level7 = st.int_pend; // see R07
    assign direct_virtual_access_bus_error = st.bus_err;
    assign acc_rdata = st.rdata;
    assign acc_rd_valid = st.rd_valid;
endmodule : ecmer_top

`default_nettype wire

// [bench/ecmer_top_asserts.sv]
// Port checker of the memory error reporting block
`include "ecmer_defs.svh"
`default_nettype none

module ecmer_top_asserts #(
    parameter int NUM_BOARDS = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register access
    input wire logic acc_board_page,
    input wire logic [7:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [31:0] acc_rdata,
    input wire logic acc_rd_valid,
    // Memory cycle
    input wire logic cyc_valid,
    input wire logic cyc_scrub,
    input wire logic cyc_write,
    input wire logic cyc_direct_virtual_access,
    input wire logic cyc_cache,
    input wire logic cyc_ue,
    // Results
    input wire logic irq_level7,
    input wire logic direct_virtual_access_bus_error,
    input wire logic [NUM_BOARDS-1:0] board_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_err_read;
        acc_rd && !acc_board_page && acc_addr == `ECMER_OFS_ERR;
    endsequence

    chk_rd_answer: assert property (acc_rd |=> acc_rd_valid)
        else $error("read not answered");
    chk_spare_bit: assert property (s_err_read |=> acc_rdata[5] == 1'b0)
        else $error("unused bit set");
    chk_irq_readback: assert property (s_err_read |=> acc_rdata[`ECMER_BIT_INT] == $past(irq_level7))
        else $error("pending bit differs from request");
    // A CE-only request trails its cause by a cycle, so skip the cycle after a write
    chk_irq_hold: assert property (irq_level7 && !acc_wr && !$past(acc_wr) |=> irq_level7)
        else $error("request dropped without write");
    chk_scrub_no_berr: assert property (cyc_valid && cyc_scrub |=> !direct_virtual_access_bus_error)
        else $error("bus error on scrub");
    chk_write_no_berr: assert property (cyc_valid && (cyc_write || cyc_cache) |=> !direct_virtual_access_bus_error)
        else $error("bus error on write or cache cycle");
    chk_berr_cause: assert property (direct_virtual_access_bus_error |-> $past(cyc_valid && cyc_ue && cyc_direct_virtual_access))
        else $error("bus error without cause");
    chk_enable_hold: assert property (!(acc_wr && acc_board_page) |=> $stable(board_enable))
        else $error("board enable moved");
endmodule : ecmer_top_asserts

bind ecmer_top ecmer_top_asserts #(.NUM_BOARDS(NUM_BOARDS)) u_chk (.clk_sys, .reset, .acc_board_page,
    .acc_addr, .acc_wr, .acc_rd, .acc_rdata, .acc_rd_valid, .cyc_valid, .cyc_scrub, .cyc_write,
    .cyc_direct_virtual_access, .cyc_cache, .cyc_ue, .irq_level7, .direct_virtual_access_bus_error, .board_enable);

`default_nettype wire

// [bench/ecmer_mem_model.sv]
// Memory boards and cache as seen by the error block
`default_nettype none

module ecmer_mem_model import ecmer_pkg::*; (
    // Clock
    input wire logic clk_sys,
    // Cycle result
    output logic cyc_valid,
    output logic cyc_scrub,
    output logic cyc_write,
    output logic cyc_direct_virtual_access,
    output logic cyc_cache,
    output ecmer_board_id_t cyc_board,
    output logic cyc_ce,
    output logic cyc_ue,
    output ecmer_syn_t cyc_syndrome,
    output ecmer_raddr_t cyc_real_addr,
    output ecmer_vaddr_t cyc_virt_addr,
    output ecmer_ctx_t cyc_context,
    // Cache events
    output logic writeback_fail_evt,
    output logic bus_timeout_evt,
    output ecmer_vaddr_t cache_fault_vaddr,
    output ecmer_ctx_t cache_fault_context
);
    timeunit 1ns;
    timeprecision 100ps;

    // Released data turns over so stale values never pass
    task automatic release_lines();
        {cyc_valid, cyc_scrub, cyc_write, cyc_direct_virtual_access, cyc_cache, cyc_ce, cyc_ue} = 7'h00;
        {writeback_fail_evt, bus_timeout_evt} = 2'h0;
        {cyc_syndrome, cyc_real_addr, cyc_virt_addr, cyc_context} =
            ~{cyc_syndrome, cyc_real_addr, cyc_virt_addr, cyc_context};
        {cache_fault_vaddr, cache_fault_context} = ~{cache_fault_vaddr, cache_fault_context};
    endtask : release_lines

    initial begin
        {cyc_board, cyc_syndrome, cyc_real_addr, cyc_virt_addr, cyc_context} = 66'h0;
        {cache_fault_vaddr, cache_fault_context} = 31'h0;
        release_lines();
    end

    // Flags are {cache, direct_virtual_access, write, scrub, ce, ue}
    task automatic mem_cycle(input logic [5:0] f, input ecmer_board_id_t b, input ecmer_vaddr_t va,
        input ecmer_ctx_t cx, input ecmer_syn_t s, input ecmer_raddr_t ra);
        @(posedge clk_sys);
        #1;
        {cyc_cache, cyc_direct_virtual_access, cyc_write, cyc_scrub, cyc_ce, cyc_ue} = f;
        cyc_valid = 1'b1;
        cyc_board = b;
        {cyc_virt_addr, cyc_context, cyc_syndrome, cyc_real_addr} = {va, cx, s, ra};
        @(posedge clk_sys);
        #1;
        release_lines();
    endtask : mem_cycle

    task automatic cache_event(input logic wb, input logic to, input ecmer_vaddr_t va, input ecmer_ctx_t cx);
        @(posedge clk_sys);
        #1;
        {writeback_fail_evt, bus_timeout_evt, cache_fault_vaddr, cache_fault_context} = {wb, to, va, cx};
        @(posedge clk_sys);
        #1;
        release_lines();
    endtask : cache_event
endmodule : ecmer_mem_model

`default_nettype wire

// [bench/ecmer_top_tb.sv]
// Self-checking bench of the memory error reporting block
`default_nettype none

module ecmer_top_tb import ecmer_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys, reset, acc_board_page, acc_wr, acc_rd, acc_rd_valid, irq_level7, direct_virtual_access_bus_error;
    logic cyc_valid, cyc_scrub, cyc_write, cyc_direct_virtual_access, cyc_cache, cyc_ce, cyc_ue;
    logic writeback_fail_evt, bus_timeout_evt;
    logic [7:0] acc_addr;
    logic [3:0] acc_byte_en;
    logic [31:0] acc_wdata, acc_rdata;
    logic [15:0] board_enable, lfsr;
    ecmer_board_id_t cyc_board;
    ecmer_syn_t cyc_syndrome;
    ecmer_raddr_t cyc_real_addr;
    ecmer_vaddr_t cyc_virt_addr, cache_fault_vaddr, va;
    ecmer_ctx_t cyc_context, cache_fault_context;
    int fails = 0;
    int compares = 0;

    ecmer_top u_dut (.clk_sys, .reset, .acc_board_page, .acc_addr, .acc_wr, .acc_rd, .acc_byte_en,
        .acc_wdata, .acc_rdata, .acc_rd_valid, .cyc_valid, .cyc_scrub, .cyc_write, .cyc_direct_virtual_access, .cyc_cache,
        .cyc_board, .cyc_ce, .cyc_ue, .cyc_syndrome, .cyc_real_addr, .cyc_virt_addr, .cyc_context,
        .writeback_fail_evt, .bus_timeout_evt, .cache_fault_vaddr, .cache_fault_context, .irq_level7,
        .direct_virtual_access_bus_error, .board_enable);

    ecmer_mem_model u_mem (.clk_sys, .cyc_valid, .cyc_scrub, .cyc_write, .cyc_direct_virtual_access, .cyc_cache,
        .cyc_board, .cyc_ce, .cyc_ue, .cyc_syndrome, .cyc_real_addr, .cyc_virt_addr, .cyc_context,
        .writeback_fail_evt, .bus_timeout_evt, .cache_fault_vaddr, .cache_fault_context);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [31:0] addr_word(input logic dv, input ecmer_ctx_t cx, input ecmer_vaddr_t a);
        return {dv, cx, a};
    endfunction : addr_word

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic pg, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        {acc_board_page, acc_addr, acc_byte_en, acc_wdata, acc_wr} = {pg, a, be, d, 1'b1};
        @(posedge clk_sys);
        #1;
        acc_wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic pg, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        #1;
        {acc_board_page, acc_addr, acc_rd} = {pg, a, 1'b1};
        @(posedge clk_sys);
        #1;
        acc_rd = 1'b0;
        check({31'h0, acc_rd_valid}, 32'h1);
        check(acc_rdata, exp);
    endtask : reg_rd

    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        #20000;
        fails++;
        stop_test();
    end

    initial begin
        reset = 1'b1;
        {acc_board_page, acc_wr, acc_rd, acc_addr, acc_byte_en, acc_wdata} = 47'h0;
        lfsr = 16'h003A;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        reg_rd(1'b0, 8'h00, 32'h0);
        reg_rd(1'b0, 8'h08, 32'h0);
        reg_wr(1'b0, 8'h00, 4'h1, 32'hFF);
        reg_rd(1'b0, 8'h00, 32'h50);
        reg_wr(1'b1, 8'h00, 4'h1, 32'h60);
        reg_wr(1'b1, 8'h10, 4'h1, 32'hE0);
        reg_rd(1'b1, 8'h10, 32'hE0);
        reg_rd(1'b1, 8'h18, 32'h0);
        check({16'h0, board_enable}, 32'h3);
        $display("Registers test done");
        u_mem.mem_cycle(6'b010001, 4'h0, 28'h1234567, 3'h5, 8'h00, 23'h0);
        check({30'h0, direct_virtual_access_bus_error, irq_level7}, 32'h3);
        reg_rd(1'b0, 8'h00, 32'hD2);
        u_mem.mem_cycle(6'b000001, 4'h0, 28'h0ABCDEF, 3'h1, 8'h00, 23'h0);
        reg_rd(1'b0, 8'h04, addr_word(1'b1, 3'h5, 28'h1234567));
        reg_wr(1'b0, 8'h04, 4'h8, 32'h0);
        reg_rd(1'b0, 8'h00, 32'h50);
        check({31'h0, irq_level7}, 32'h0);
        u_mem.mem_cycle(6'b010101, 4'h1, 28'h1, 3'h1, 8'h00, 23'h0);
        check({31'h0, direct_virtual_access_bus_error}, 32'h0);
        reg_rd(1'b0, 8'h00, 32'h50);
        u_mem.mem_cycle(6'b011001, 4'h0, 28'h2, 3'h2, 8'h00, 23'h0);
        check({31'h0, direct_virtual_access_bus_error}, 32'h0);
        u_mem.mem_cycle(6'b110001, 4'h0, 28'h3, 3'h3, 8'h00, 23'h0);
        check({31'h0, direct_virtual_access_bus_error}, 32'h0);
        reg_rd(1'b0, 8'h04, addr_word(1'b1, 3'h2, 28'h2));
        reg_wr(1'b0, 8'h04, 4'h8, 32'h0);
        $display("Uncorrectable test done");
        u_mem.mem_cycle(6'b000010, 4'h2, 28'h0, 3'h0, 8'h11, 23'h7);
        reg_rd(1'b0, 8'h00, 32'h50);
        u_mem.mem_cycle(6'b000010, 4'h0, 28'h0, 3'h0, 8'hA5, 23'h1234);
        u_mem.mem_cycle(6'b000010, 4'h0, 28'h0, 3'h0, 8'h5A, 23'h4321);
        reg_rd(1'b1, 8'h04, {8'hA5, 23'h1234, 1'b1});
        reg_rd(1'b0, 8'h00, 32'hD1);
        reg_wr(1'b0, 8'h04, 4'h8, 32'h0);
        reg_rd(1'b0, 8'h00, 32'hD1);
        reg_wr(1'b1, 8'h04, 4'h8, 32'h0);
        reg_rd(1'b0, 8'h00, 32'h50);
        u_mem.mem_cycle(6'b000110, 4'h1, 28'h0, 3'h0, 8'h3C, 23'h55);
        reg_rd(1'b0, 8'h00, 32'hD1);
        reg_wr(1'b1, 8'h14, 4'h8, 32'h0);
        $display("Correctable test done");
        u_mem.cache_event(1'b1, 1'b0, 28'hFEDCBA9, 3'h7);
        check({31'h0, irq_level7}, 32'h1);
        u_mem.cache_event(1'b0, 1'b1, 28'h1, 3'h1);
        reg_rd(1'b0, 8'h00, 32'hDC);
        reg_rd(1'b0, 8'h04, addr_word(1'b0, 3'h7, 28'hFEDCBA9));
        reg_wr(1'b0, 8'h04, 4'h8, 32'h0);
        reg_wr(1'b0, 8'h00, 4'h1, 32'h10);
        u_mem.mem_cycle(6'b000001, 4'h0, 28'h4, 3'h4, 8'h00, 23'h0);
        check({31'h0, irq_level7}, 32'h0);
        reg_wr(1'b0, 8'h00, 4'h1, 32'h50);
        reg_rd(1'b0, 8'h00, 32'hD2);
        reg_wr(1'b0, 8'h04, 4'h8, 32'h0);
        $display("Cache event test done");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            va = {lfsr[11:0], lfsr};
            u_mem.mem_cycle({1'b0, lfsr[0], 4'b0001}, 4'h0, va, lfsr[3:1], lfsr[7:0], {lfsr[6:0], lfsr});
            check({31'h0, direct_virtual_access_bus_error}, {31'h0, lfsr[0]});
            reg_rd(1'b0, 8'h04, addr_word(lfsr[0], lfsr[3:1], va));
            reg_wr(1'b0, 8'h04, 4'h8, 32'h0);
        end
        $display("Random test done");
        stop_test();
    end
endmodule : ecmer_top_tb

`default_nettype wire
